// file: hdl/periph_mirror_pkg.sv
// constants and types shared by the peripheral-enable mirror block
package periph_mirror_pkg;
  localparam int DATA_W = 16;
  localparam int ADDR_W = 16;
  // extension-bus byte address of the mirror register
  localparam logic [ADDR_W-1:0] MIRROR_ADDR = 16'hEB7E;
  // power-on value chosen for a register whose reset value is undefined
  localparam logic [DATA_W-1:0] MIRROR_RESET = 16'h0000;
  // bits 11..0 hold enables, bits 15..12 are unused
  localparam logic [DATA_W-1:0] USED_MASK = 16'h0FFF;
  localparam logic [DATA_W-1:0] READ_VALUE = 16'h0000;
  // enable bit positions, shared with the peripheral enable register
  localparam int FIRST_BUS_CTRL_BIT = 0;
  localparam int SECOND_BUS_CTRL_BIT = 1;
  localparam int FIRST_RAM_BIT = 2;
  localparam int SECOND_RAM_BIT = 3;
  localparam int CLOCK_CAL_BIT = 4;
  localparam int FLASH_BIT = 5;
  localparam int PULSE_WIDTH_BIT = 6;
  localparam int ASYNC_SERIAL_BIT = 7;
  localparam int SYNC_SERIAL_BIT = 8;
  localparam int TWO_WIRE_BIT = 9;
  localparam int MISC_BIT = 10;
  localparam int PORT_BIT = 11;
  // what memory segment 8 maps to
  typedef enum logic [1:0] {
    SEG8_EXTERNAL,
    SEG8_FLASH,
    SEG8_RESERVED
  } seg8_map_t;
endpackage

// file: hdl/seg8_decoder.sv
// combinational decoder for the memory segment 8 mapping
`timescale 1ns/10ps
`default_nettype none
module seg8_decoder (
  // configuration bits
  input wire logic internal_rom_enable_i,
  input wire logic extension_bus_enable_i,
  input wire logic second_ram_enable_i,
  input wire logic ext_flash_enable_i,
  // resulting mapping
  output var periph_mirror_pkg::seg8_map_t map_o
);
  import periph_mirror_pkg::*;

  // rom enable overrides everything; bus on with ram2 or flash on is reserved, else external (see [RULE9])
  always_comb begin
    if (internal_rom_enable_i) begin
      map_o = SEG8_FLASH;
    end else if (!extension_bus_enable_i) begin
      map_o = SEG8_EXTERNAL;
    end else if (!second_ram_enable_i && !ext_flash_enable_i) begin
      map_o = SEG8_EXTERNAL;
    end else begin
      map_o = SEG8_RESERVED; // decoded as unmapped (see [RULE11])
    end
  end
endmodule
`default_nettype wire

// file: hdl/periph_enable_mirror_config.sv
// peripheral-enable mirror register, segment 8 decode, oscillator control
//
// What this block does
// [RULE1] write-only 16-bit mirror register at extension-bus address EB7Eh, reset undefined
// [RULE2] software copies enable register into mirror when bus and peripherals are on
// [RULE3] software writes mirror only after both configuration registers are final
// [RULE4] mirror bits 11..0 follow the enable layout; bits 15..12 unused
// [RULE5] in emulation mode all peripheral enable bits read as set
// [RULE6] software writes zero to reserved bits of the peripheral enable register
// [RULE7] real-time clock disabled plus power-down switches the main oscillator off
// [RULE8] real-time clock enabled: oscillator-off bit chooses stop or run in power-down
// [RULE9] segment 8 maps to flash, external memory or reserved from enable bits
// [RULE10] reads of the mirror leave its contents alone; read data is undefined
// [RULE11] software avoids reserved segment 8 combinations; decoder treats them as unmapped
`timescale 1ns/10ps
`default_nettype none
module periph_enable_mirror_config (
  // clock and reset
  input wire logic clk_i,
  input wire logic sys_rst_i,
  // internal extension bus
  input wire logic [periph_mirror_pkg::ADDR_W-1:0] ext_addr_i,
  input wire logic [periph_mirror_pkg::DATA_W-1:0] ext_wdata_i,
  input wire logic ext_wr_i,
  input wire logic ext_rd_i,
  output logic [periph_mirror_pkg::DATA_W-1:0] ext_rdata_o,
  output logic ext_ack_o,
  // system and peripheral configuration
  input wire logic internal_rom_enable_i,
  input wire logic extension_bus_enable_i,
  input wire logic [periph_mirror_pkg::DATA_W-1:0] periph_enable_register_i,
  input wire logic emulation_mode_i,
  // power management
  input wire logic realtime_clock_enable_i,
  input wire logic oscillator_off_in_powerdown_i,
  input wire logic powerdown_i,
  // results
  output logic [periph_mirror_pkg::DATA_W-1:0] mirror_o,
  output logic seg8_flash_o,
  output logic seg8_external_o,
  output logic seg8_reserved_o,
  output logic main_osc_off_o
);
  import periph_mirror_pkg::*;

  // ***************************************************************
  // state
  // ***************************************************************
  typedef struct packed {
    logic [DATA_W-1:0] mirror;
    logic [DATA_W-1:0] mirror_out;
    logic [DATA_W-1:0] rdata;
    logic ack;
    logic seg8_flash;
    logic seg8_ext;
    logic seg8_rsvd;
    logic osc_off;
  } state_t;

  state_t state_reg;
  state_t state_next;
  seg8_map_t seg8_map;
  logic hit;

  // ***************************************************************
  // segment 8 decode
  // ***************************************************************
  seg8_decoder seg8_decoder_inst (
    .internal_rom_enable_i(internal_rom_enable_i),
    .extension_bus_enable_i(extension_bus_enable_i),
    .second_ram_enable_i(periph_enable_register_i[SECOND_RAM_BIT]),
    .ext_flash_enable_i(periph_enable_register_i[FLASH_BIT]),
    .map_o(seg8_map)
  );

  // ***************************************************************
  // extension bus decode
  // ***************************************************************
  // only the mirror address answers; other addresses get no ack
  assign hit = (ext_addr_i == MIRROR_ADDR);

  // ***************************************************************
  // next-state logic
  // ***************************************************************
  // one pass fills the whole next state, so no field is left latched
  always_comb begin
    state_next = state_reg;
    state_next.ack = hit && (ext_wr_i || ext_rd_i);
    // write-only: reads return a fixed value, storage untouched (see [RULE10])
    state_next.rdata = READ_VALUE;
    if (hit && ext_wr_i) begin
      // unused upper bits are never stored (see [RULE1]) (see [RULE4])
      state_next.mirror = ext_wdata_i & USED_MASK;
    end
    // emulation forces every enable on, stored value kept (see [RULE5])
    if (emulation_mode_i) begin
      state_next.mirror_out = USED_MASK;
    end else begin
      state_next.mirror_out = state_next.mirror;
    end
    state_next.seg8_flash = (seg8_map == SEG8_FLASH); // see [RULE9]
    state_next.seg8_ext = (seg8_map == SEG8_EXTERNAL);
    state_next.seg8_rsvd = (seg8_map == SEG8_RESERVED);
    // rtc off stops the oscillator in power-down; rtc on lets its control bit decide
    if (!realtime_clock_enable_i) begin
      state_next.osc_off = powerdown_i; // see [RULE7]
    end else begin
      state_next.osc_off = powerdown_i && oscillator_off_in_powerdown_i; // see [RULE8]
    end
  end

  // ***************************************************************
  // state register and outputs
  // ***************************************************************
  // state register; mirror has no defined reset, zero is used for safety
  always_ff @(posedge clk_i or posedge sys_rst_i) begin
    if (sys_rst_i) begin
      state_reg <= '{mirror: MIRROR_RESET, mirror_out: MIRROR_RESET,
                     rdata: READ_VALUE, default: 1'h0};
    end else begin
      state_reg <= state_next;
    end
  end

  // outputs straight from flip-flops
  assign mirror_o = state_reg.mirror_out;
  assign ext_rdata_o = state_reg.rdata;
  assign ext_ack_o = state_reg.ack;
  assign seg8_flash_o = state_reg.seg8_flash;
  assign seg8_external_o = state_reg.seg8_ext;
  assign seg8_reserved_o = state_reg.seg8_rsvd;
  assign main_osc_off_o = state_reg.osc_off;

  // ***************************************************************
  // assertions
  // ***************************************************************
  // write data lands in the visible mirror one cycle later
  mirror_write_a: assert property ( // see [RULE1]
    @(posedge clk_i) disable iff (sys_rst_i)
    (ext_wr_i && hit && !emulation_mode_i) |=>
    (mirror_o == ($past(ext_wdata_i) & USED_MASK)))
    else $error("mirror did not capture write data");

  // the stored word keeps taking writes while emulation hides it
  stored_write_a: assert property ( // see [RULE5]
    @(posedge clk_i) disable iff (sys_rst_i)
    (ext_wr_i && hit) |=>
    (state_reg.mirror == ($past(ext_wdata_i) & USED_MASK)))
    else $error("stored mirror lost a write");

  // every access to the mirror address is acknowledged next cycle
  access_ack_a: assert property ( // see [RULE1]
    @(posedge clk_i) disable iff (sys_rst_i)
    (hit && (ext_wr_i || ext_rd_i)) |=> ext_ack_o)
    else $error("mirror access not acknowledged");

  // other addresses are ignored
  unmapped_ack_a: assert property ( // see [RULE1]
    @(posedge clk_i) disable iff (sys_rst_i)
    !hit |=> !ext_ack_o)
    else $error("unmapped address acknowledged");

  // bits above the port enable are never stored or shown
  unused_bits_a: assert property ( // see [RULE4]
    @(posedge clk_i) disable iff (sys_rst_i)
    mirror_o[DATA_W-1:PORT_BIT+1] == '0)
    else $error("unused mirror bits not zero");

  // emulation hides the stored word behind all-ones enables
  emulation_all_a: assert property ( // see [RULE5]
    @(posedge clk_i) disable iff (sys_rst_i)
    emulation_mode_i |=> (mirror_o == USED_MASK))
    else $error("emulation mode did not force all enables");

  // outside emulation the stored word is what the mirror shows
  emulation_exit_a: assert property ( // see [RULE5]
    @(posedge clk_i) disable iff (sys_rst_i)
    (!emulation_mode_i && !(hit && ext_wr_i)) |=>
    (mirror_o == $past(state_reg.mirror)))
    else $error("stored mirror not shown outside emulation");

  // a read neither stores nor clears anything, even back to back
  read_keeps_a: assert property ( // see [RULE10]
    @(posedge clk_i) disable iff (sys_rst_i)
    (ext_rd_i && !ext_wr_i) |=>
    (state_reg.mirror == $past(state_reg.mirror)))
    else $error("read disturbed mirror contents");

  // power-down with the clock disabled always stops the oscillator
  osc_rtc_off_a: assert property ( // see [RULE7]
    @(posedge clk_i) disable iff (sys_rst_i)
    (powerdown_i && !realtime_clock_enable_i) |=> main_osc_off_o)
    else $error("oscillator not stopped with rtc disabled");

  // with the clock enabled its control bit decides
  osc_rtc_sel_a: assert property ( // see [RULE8]
    @(posedge clk_i) disable iff (sys_rst_i)
    (powerdown_i && realtime_clock_enable_i) |=>
    (main_osc_off_o == $past(oscillator_off_in_powerdown_i)))
    else $error("oscillator control bit not followed");

  // outside power-down the oscillator keeps running
  osc_running_a: assert property ( // see [RULE8]
    @(posedge clk_i) disable iff (sys_rst_i)
    !powerdown_i |=> !main_osc_off_o)
    else $error("oscillator stopped outside power-down");

  // rom enable wins over every other bit
  seg8_flash_a: assert property ( // see [RULE9]
    @(posedge clk_i) disable iff (sys_rst_i)
    internal_rom_enable_i |=> (seg8_flash_o && !seg8_external_o))
    else $error("segment 8 not mapped to flash");

  // bus off, or bus on with ram2 and flash off, means external memory
  seg8_ext_a: assert property ( // see [RULE9]
    @(posedge clk_i) disable iff (sys_rst_i)
    (!internal_rom_enable_i && (!extension_bus_enable_i ||
      (!periph_enable_register_i[SECOND_RAM_BIT] &&
       !periph_enable_register_i[FLASH_BIT]))) |=>
    (seg8_external_o && !seg8_reserved_o))
    else $error("segment 8 not mapped to external memory");

  // the remaining combinations are flagged, never mapped
  seg8_rsvd_a: assert property ( // see [RULE9]
    @(posedge clk_i) disable iff (sys_rst_i)
    (!internal_rom_enable_i && extension_bus_enable_i &&
     (periph_enable_register_i[SECOND_RAM_BIT] ||
      periph_enable_register_i[FLASH_BIT])) |=>
    (seg8_reserved_o && !seg8_flash_o && !seg8_external_o))
    else $error("reserved segment 8 setting not flagged");

  // exactly one mapping is shown once out of reset
  seg8_onehot_a: assert property ( // see [RULE9]
    @(posedge clk_i) disable iff (sys_rst_i)
    !sys_rst_i |=>
    $onehot({seg8_flash_o, seg8_external_o, seg8_reserved_o}))
    else $error("segment 8 mapping not one-hot");
endmodule
`default_nettype wire

// file: tb/sw_config_model.sv
// software-side model: programs the enable register, decides the copy
`timescale 1ns/10ps
`default_nettype none
module sw_config_model (
  // requested settings
  input wire logic [15:0] wanted_i,
  input wire logic extension_bus_enable_i,
  // register image and copy decision
  output logic [15:0] periph_enable_register_o,
  output logic copy_needed_o
);
  // reserved bits always go out low, whatever the caller asked for
  assign periph_enable_register_o = wanted_i & 16'h0FFF;
  // copy needed only with the bus on and a masked peripheral active
  assign copy_needed_o = extension_bus_enable_i &&
    ((periph_enable_register_o & 16'h07D3) != 16'h0000);
endmodule
`default_nettype wire

// file: tb/tb_top.sv
// self-checking bench for the peripheral-enable mirror block
`timescale 1ns/10ps
`default_nettype none
`define CHK(got, exp) begin checked++; if ((got) !== (exp)) begin \
  miscompares++; $display("mismatch at %0t: got %h exp %h", $time, \
  got, exp); end end
module tb_top;
  import periph_mirror_pkg::*;
  logic clk_i = 1'h0;
  logic sys_rst_i = 1'h1;
  logic [15:0] addr = 16'h0000, wdata = 16'h0000, wanted = 16'h0000;
  logic wr = 1'h0, rd = 1'h0, rom = 1'h0, bus_en = 1'h0, emu = 1'h0;
  logic rtc = 1'h0, osc_off = 1'h0, pd = 1'h0, copy;
  logic [15:0] rdata, mirror, perif;
  logic ack, s_fl, s_ex, s_rs, osc;
  int miscompares = 0;
  int checked = 0;
  always #2 clk_i = ~clk_i;
  periph_enable_mirror_config periph_enable_mirror_config_inst (
    .clk_i(clk_i), .sys_rst_i(sys_rst_i), .ext_addr_i(addr),
    .ext_wdata_i(wdata), .ext_wr_i(wr), .ext_rd_i(rd),
    .ext_rdata_o(rdata), .ext_ack_o(ack), .internal_rom_enable_i(rom),
    .extension_bus_enable_i(bus_en), .periph_enable_register_i(perif),
    .emulation_mode_i(emu), .realtime_clock_enable_i(rtc),
    .oscillator_off_in_powerdown_i(osc_off), .powerdown_i(pd),
    .mirror_o(mirror), .seg8_flash_o(s_fl), .seg8_external_o(s_ex),
    .seg8_reserved_o(s_rs), .main_osc_off_o(osc));
  sw_config_model sw_config_model_inst (
    .wanted_i(wanted), .extension_bus_enable_i(bus_en),
    .periph_enable_register_o(perif), .copy_needed_o(copy));
  // expected segment 8 one-hot {flash, external, reserved}
  function automatic logic [2:0] seg_exp(input logic [3:0] c);
    if (c[3]) return 3'h4;
    if (!c[2] || c[1:0] == 2'h0) return 3'h2;
    return 3'h1;
  endfunction
  // one-cycle strobe at a falling edge; ack must last exactly one cycle
  task automatic access(input logic w, input logic [15:0] a, d,
                        input logic exp_ack);
    addr = a;
    wdata = d;
    wr = w;
    rd = ~w;
    @(negedge clk_i);
    wr = 1'h0;
    rd = 1'h0;
    `CHK(ack, exp_ack)
    @(negedge clk_i);
    `CHK(ack, 1'h0)
  endtask
  task automatic final_report();
    if (miscompares == 0 && checked > 0) begin
      $display("TB: PASS");
    end else begin
      $display("TB: FAIL");
    end
    $finish;
  endtask
  // watchdog: the whole sequence needs well under a thousand cycles
  initial begin
    #8000;
    miscompares++;
    final_report();
  end
  initial begin
    repeat (20) @(negedge clk_i);
    sys_rst_i = 1'h0;
    @(negedge clk_i);
    // unused upper bits of the write are dropped
    access(1'h1, MIRROR_ADDR, 16'hFABC, 1'h1);
    `CHK(mirror, 16'h0ABC)
    access(1'h0, MIRROR_ADDR, 16'h0000, 1'h1);
    `CHK(mirror, 16'h0ABC)
    access(1'h1, 16'hEB7C, 16'h0123, 1'h0);
    `CHK(mirror, 16'h0ABC)
    // emulation shows all enables; a write meanwhile is kept for later
    emu = 1'h1;
    @(negedge clk_i);
    `CHK(mirror, 16'h0FFF)
    access(1'h1, MIRROR_ADDR, 16'h0DEF, 1'h1);
    `CHK(mirror, 16'h0FFF)
    emu = 1'h0;
    @(negedge clk_i);
    `CHK(mirror, 16'h0DEF)
    // both configuration registers settle before the copy is made
    bus_en = 1'h1;
    wanted = 16'hF0BC;
    @(negedge clk_i);
    if (copy) access(1'h1, MIRROR_ADDR, perif, 1'h1);
    `CHK(mirror, 16'h00BC)
    // every power-down, clock-enable and oscillator-off combination
    for (int i = 0; i < 8; i++) begin
      {pd, rtc, osc_off} = i[2:0];
      @(negedge clk_i);
      `CHK(osc, pd & (~rtc | osc_off))
    end
    // all sixteen segment 8 enable combinations
    for (int i = 0; i < 16; i++) begin
      {rom, bus_en} = i[3:2];
      wanted = {10'h000, i[0], 1'h0, i[1], 3'h0};
      @(negedge clk_i);
      `CHK({s_fl, s_ex, s_rs}, seg_exp(i[3:0]))
    end
    final_report();
  end
endmodule
`default_nettype wire
